// file: rios_ctrl.v
// Remote discrete I/O status and control logic with an AHB-Lite register slave
`timescale 1ns/1ps
`include "rios_defs.vh"

module rios_ctrl
#(
  parameter NUM_ROBOTS = 16
)
(
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Remote inputs from the master equipment
  input wire expert_input,
  input wire [4:0] robot_select_bits,
  input wire select_output_robot,
  input wire [3:0] alarm_select_bits,
  input wire alarm_clear_request,
  input wire forced_low_power_input,
  input wire reset_input,
  input wire command_start,
  input wire command_is_high_power,
  // Controller core state
  input wire startup_done,
  input wire task_running,
  input wire task_paused,
  input wire error_event,
  input wire estop_active,
  input wire guard_open,
  input wire critical_error,
  input wire warning_event,
  input wire command_done,
  input wire [NUM_ROBOTS-1:0] robot_motor_on,
  input wire [NUM_ROBOTS-1:0] robot_at_home,
  input wire [NUM_ROBOTS-1:0] robot_high_power,
  input wire [NUM_ROBOTS-1:0] robot_uncalibrated,
  input wire [NUM_ROBOTS-1:0] robot_await_recovery,
  input wire [NUM_ROBOTS-1:0] robot_in_recovery,
  // Remote status outputs
  output reg ready_flag,
  output reg running_flag,
  output reg paused_flag,
  output reg error_flag,
  output reg emergency_stop_flag,
  output reg guard_open_flag,
  output reg fatal_error_flag,
  output reg warning_flag,
  output reg motors_energized_flag,
  output reg home_position_flag,
  output reg high_power_flag,
  output reg calibration_needed_flag,
  output reg recovery_pending_flag,
  output reg recovery_active_flag,
  output reg command_busy_flag,
  output reg command_reject_flag,
  // Actions toward the controller core
  output reg stop_all_pulse,
  output reg stop_ordinary_pulse,
  output reg temp_stop_level,
  output reg force_low_power,
  output reg high_power_accept,
  output reg command_accept_pulse,
  output reg [8:0] alarm_clear_pulse
);

  // ********************************************************************
  // Helper functions
  // ********************************************************************

  // Alarm number to one-hot clear vector, bit 0 is alarm 1
  function [8:0] alarm_onehot;
    input [3:0] num;
    reg [8:0] v;
    begin
      v = 9'h000;
      if ((num >= `RIOS_ALARM_MIN) && (num <= `RIOS_ALARM_MAX))
      begin
        v[num - `RIOS_ALARM_MIN] = 1'b1;
      end
      alarm_onehot = v;
    end
  endfunction

  // Pick the flag of one robot; number zero is handled by the caller
  function pick_robot;
    input [NUM_ROBOTS-1:0] vec;
    input [4:0] num;
    integer i;
    reg hit;
    begin
      hit = 1'b0;
      for (i = 0; i < NUM_ROBOTS; i = i + 1)
      begin
        if (num == i + 1)
        begin
          hit = vec[i];
        end
      end
      pick_robot = hit;
    end
  endfunction

  // ********************************************************************
  // Register bus
  // ********************************************************************

  reg [1:0] pref_r;
  reg [4:0] out_robot_r;
  reg [8:0] alarm_done_r;
  reg wr_pend_r;
  reg [7:0] addr_r;
  wire addr_phase;

  // Slave always ready with OKAY; single-word accesses only
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel & hready & htrans[`RIOS_HTRANS_ACT];

  // Latch address phase for the following data phase
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_r <= addr_phase & hwrite;
      addr_r <= haddr[7:0];
    end
  end

  // Preference write in the data phase; only the low bits are stored
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pref_r <= `RIOS_PREF_RST;
    end
    else if (wr_pend_r && (addr_r == `RIOS_OFS_PREF))
    begin
      pref_r <= hwdata[1:0];
    end
  end

  // Read data registered so it stands in the data phase
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hrdata <= 32'h00000000;
    end
    else if (addr_phase && !hwrite)
    begin
      case (haddr[7:0])
        `RIOS_OFS_PREF: hrdata <= {30'h00000000, pref_r};
        `RIOS_OFS_STATUS: hrdata <= {16'h0000, command_reject_flag,
          command_busy_flag, recovery_active_flag, recovery_pending_flag,
          calibration_needed_flag, high_power_flag, home_position_flag,
          motors_energized_flag, warning_flag, fatal_error_flag,
          guard_open_flag, emergency_stop_flag, error_flag, paused_flag,
          running_flag, ready_flag};
        `RIOS_OFS_ROBOT: hrdata <= {27'h0000000, out_robot_r};
        `RIOS_OFS_ALARM: hrdata <= {23'h000000, alarm_done_r};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // ********************************************************************
  // Edge detection of remote inputs
  // ********************************************************************

  reg expert_d_r;
  reg flp_d_r;
  reg clr_d_r;
  reg sel_d_r;
  reg cmd_d_r;
  wire expert_fall;
  wire flp_edge;
  wire forcing_now;
  wire clr_rise;
  wire sel_rise;
  wire cmd_rise;

  // Previous levels; inputs are synchronous to ref_clk
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      expert_d_r <= 1'b0;
      flp_d_r <= 1'b0;
      clr_d_r <= 1'b0;
      sel_d_r <= 1'b0;
      cmd_d_r <= 1'b0;
    end
    else
    begin
      expert_d_r <= expert_input;
      flp_d_r <= forced_low_power_input;
      clr_d_r <= alarm_clear_request;
      sel_d_r <= select_output_robot;
      cmd_d_r <= command_start;
    end
  end

  assign expert_fall = expert_d_r & ~expert_input;
  assign flp_edge = flp_d_r ^ forced_low_power_input;
  // Forcing level is high with polarity bit 0, low with polarity bit 1
  assign forcing_now = forced_low_power_input ^ pref_r[`RIOS_PREF_POL];
  assign clr_rise = alarm_clear_request & ~clr_d_r;
  assign sel_rise = select_output_robot & ~sel_d_r;
  assign cmd_rise = command_start & ~cmd_d_r;

  // ********************************************************************
  // Output robot selection and alarm clearing
  // ********************************************************************

  // Held until the master changes it or the block is reset
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_robot_r <= `RIOS_ROBOT_ALL;
    end
    else if (sel_rise)
    begin
      out_robot_r <= robot_select_bits;
    end
  end

  // Only the selected alarm is cleared; invalid numbers clear nothing
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      alarm_clear_pulse <= 9'h000;
      alarm_done_r <= 9'h000;
    end
    else
    begin
      alarm_clear_pulse <= clr_rise ? alarm_onehot(alarm_select_bits) : 9'h000;
      if (clr_rise)
      begin
        alarm_done_r <= alarm_onehot(alarm_select_bits);
      end
    end
  end

  // ********************************************************************
  // Forced low power policy and task stopping
  // ********************************************************************

  wire hp_cmd_ok;
  assign hp_cmd_ok = ~command_is_high_power | high_power_accept;

  // Edge table of the two preference bits
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stop_all_pulse <= 1'b0;
      stop_ordinary_pulse <= 1'b0;
      temp_stop_level <= 1'b0;
      force_low_power <= 1'b0;
      high_power_accept <= 1'b1;
    end
    else
    begin
      // Expert drop spares the nonstop task class
      stop_ordinary_pulse <= expert_fall;
      stop_all_pulse <= flp_edge & ~pref_r[`RIOS_PREF_PAUSE];
      if (flp_edge && !pref_r[`RIOS_PREF_PAUSE])
      begin
        // Any edge stops everything and pins power low
        temp_stop_level <= 1'b0;
        force_low_power <= 1'b1;
        high_power_accept <= ~forcing_now;
      end
      else if (flp_edge)
      begin
        // Pause on entry, resume on exit
        temp_stop_level <= forcing_now;
        force_low_power <= forcing_now;
        high_power_accept <= ~forcing_now;
      end
      else if (command_accept_pulse && command_is_high_power)
      begin
        // An accepted high power command lifts the low-only hold
        force_low_power <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Command busy and reject
  // ********************************************************************

  // Expert input has no path into these flags
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      command_busy_flag <= 1'b0;
      command_reject_flag <= 1'b0;
      command_accept_pulse <= 1'b0;
    end
    else
    begin
      command_accept_pulse <= 1'b0;
      if (command_done) // Done frees busy even beside a refused edge
      begin
        command_busy_flag <= 1'b0;
      end
      if (cmd_rise && !command_busy_flag && hp_cmd_ok && !fatal_error_flag)
      begin
        command_busy_flag <= 1'b1;
        command_reject_flag <= 1'b0;
        command_accept_pulse <= 1'b1;
      end
      else if (cmd_rise)
      begin
        command_reject_flag <= 1'b1;
      end
    end
  end

  // ********************************************************************
  // Remote status outputs
  // ********************************************************************

  wire all_sel;
  assign all_sel = (out_robot_r == `RIOS_ROBOT_ALL);

  // Registered so every flag moves with the edge of its driving state
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ready_flag <= 1'b0;
      running_flag <= 1'b0;
      paused_flag <= 1'b0;
      error_flag <= 1'b0;
      emergency_stop_flag <= 1'b0;
      guard_open_flag <= 1'b0;
      fatal_error_flag <= 1'b0;
      warning_flag <= 1'b0;
      motors_energized_flag <= 1'b0;
      home_position_flag <= 1'b0;
      high_power_flag <= 1'b0;
      calibration_needed_flag <= 1'b0;
      recovery_pending_flag <= 1'b0;
      recovery_active_flag <= 1'b0;
    end
    else
    begin
      ready_flag <= startup_done & ~task_running;
      running_flag <= task_running & ~task_paused;
      paused_flag <= task_paused;
      // New error wins over a simultaneous reset input
      if (error_event)
      begin
        error_flag <= 1'b1;
      end
      else if (reset_input)
      begin
        error_flag <= 1'b0;
      end
      emergency_stop_flag <= estop_active;
      guard_open_flag <= guard_open;
      // Only nrst clears it; reset_input is ignored here
      if (critical_error)
      begin
        fatal_error_flag <= 1'b1;
      end
      warning_flag <= warning_event;
      // All robots: any motor on, all at home, any high, any uncalibrated
      if (all_sel)
      begin
        motors_energized_flag <= |robot_motor_on;
        home_position_flag <= &robot_at_home;
        high_power_flag <= |robot_high_power;
        calibration_needed_flag <= |robot_uncalibrated;
      end
      else
      begin
        motors_energized_flag <= pick_robot(robot_motor_on, out_robot_r);
        home_position_flag <= pick_robot(robot_at_home, out_robot_r);
        high_power_flag <= pick_robot(robot_high_power, out_robot_r);
        calibration_needed_flag <= pick_robot(robot_uncalibrated, out_robot_r);
      end
      recovery_pending_flag <= |robot_await_recovery;
      recovery_active_flag <= |robot_in_recovery;
    end
  end

endmodule

// file: rios_defs.vh
// Constants for the remote discrete I/O status and control block
// Operation
// - Expert-only input never changes command busy or command reject flags.
// - Nonstop-class tasks keep running whatever the expert-only input does.
// - Expert-only input falling stops ordinary running tasks and executing commands.
// - Select strobe latches robot select bits to choose the per-robot outputs.
// - Chosen output robot held until changed or reset; default covers all.
// - Alarm select bits weighted 1,2,4,8 decode alarm number 1 to 9.
// - Alarm clear request cancels only the alarm number on the select bits.
// - Preference bit one sets forcing level: 0 high, 1 low.
// - Pref two clear: any edge stops all, holds low power; accept after leaving.
// - Pref two set: edge in pauses, forces low, rejects; edge out resumes, accepts.
// - Ready asserted when startup complete and no task running.
// - Running asserted while a task runs, forced low while paused.
// - Paused asserted whenever at least one paused task exists.
// - Error asserted on error and held until the reset input clears it.
// - Emergency stop output on estop; guard open output while safeguard open.
// - Fatal error asserted on critical error; reset input cannot clear it.
// - Warning asserted on warning; tasks keep running normally.
// - Motor, home, high power, calibration outputs reflect the selected robot.
// - Recovery pending asserted while any robot awaits recovery.
// - Recovery active asserted while any robot executes recovery.
// - Command busy asserted while a remote command is executing.
// - Command reject asserted when a remote command cannot be accepted.
// - Robot select bits weighted 1..16 form robot number; zero selects all.
`ifndef RIOS_DEFS_VH
`define RIOS_DEFS_VH

// Register byte offsets
`define RIOS_OFS_PREF 8'h00
`define RIOS_OFS_STATUS 8'h04
`define RIOS_OFS_ROBOT 8'h08
`define RIOS_OFS_ALARM 8'h0c

// Preference register fields
`define RIOS_PREF_POL 0
`define RIOS_PREF_PAUSE 1
`define RIOS_PREF_RST 2'h0

// Status bit positions
`define RIOS_ST_READY 0
`define RIOS_ST_RUN 1
`define RIOS_ST_PAUSE 2
`define RIOS_ST_ERR 3
`define RIOS_ST_ESTOP 4
`define RIOS_ST_GUARD 5
`define RIOS_ST_FATAL 6
`define RIOS_ST_WARN 7

// Alarm numbering
`define RIOS_ALARM_MIN 4'h1
`define RIOS_ALARM_MAX 4'h9

// Robot selection
`define RIOS_ROBOT_ALL 5'h00

// AHB transfer type bit that marks an active transfer
`define RIOS_HTRANS_ACT 1

`endif

// file: rios_ctrl_properties.sv
// Concurrent checks on the ports of the remote I/O status block
`timescale 1ns/1ps
module rios_ctrl_chk
(
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Remote and core inputs
  input wire startup_done,
  input wire task_running,
  input wire error_event,
  input wire reset_input,
  input wire estop_active,
  input wire expert_input,
  input wire [3:0] alarm_select_bits,
  input wire alarm_clear_request,
  input wire command_start,
  input wire command_done,
  // Status and action outputs
  input wire ready_flag,
  input wire running_flag,
  input wire paused_flag,
  input wire error_flag,
  input wire emergency_stop_flag,
  input wire fatal_error_flag,
  input wire command_busy_flag,
  input wire command_reject_flag,
  input wire command_accept_pulse,
  input wire stop_ordinary_pulse,
  input wire [8:0] alarm_clear_pulse
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // Flags tied to their causes one edge earlier, held once set, and paused against running
  ready_src_a: assert property (
    ready_flag |-> $past(startup_done && !task_running))
    else $error("ready flag without cause");
  run_pause_a: assert property (
    paused_flag |-> !running_flag)
    else $error("running shown while paused");
  err_set_a: assert property (
    error_event |=> error_flag)
    else $error("error flag missed");
  err_hold_a: assert property (
    error_flag && !reset_input |=> error_flag)
    else $error("error flag dropped early");
  fatal_keep_a: assert property (
    fatal_error_flag |=> fatal_error_flag)
    else $error("fatal flag cleared");
  estop_out_a: assert property (
    estop_active |=> emergency_stop_flag)
    else $error("estop flag missed");
  // Expert fall stops ordinary work but leaves command flags alone
  expert_stop_a: assert property (
    $fell(expert_input) |=> stop_ordinary_pulse ##1 !stop_ordinary_pulse)
    else $error("expert fall gave no single stop pulse");
  expert_cmd_a: assert property (
    $fell(expert_input) && !$rose(command_start) && !command_done
    |=> $stable(command_busy_flag) && $stable(command_reject_flag))
    else $error("expert input moved command flags");
  busy_keep_a: assert property (
    command_busy_flag && !command_done |=> command_busy_flag)
    else $error("busy dropped without done");
  cmd_accept_a: assert property (
    command_accept_pulse |-> command_busy_flag && !command_reject_flag)
    else $error("accept pulse without busy");
  alarm_one_a: assert property (
    $rose(alarm_clear_request) && alarm_select_bits inside {[4'h1:4'h9]}
    |=> alarm_clear_pulse == 9'h001 << ($past(alarm_select_bits) - 4'h1)
    ##1 alarm_clear_pulse == 9'h000)
    else $error("wrong alarm cleared");
  // Main scenarios reached
  cover property ($fell(expert_input));
  cover property (alarm_clear_pulse != 9'h000);
  cover property (error_flag && fatal_error_flag);
  cover property (command_accept_pulse);
endmodule

bind rios_ctrl rios_ctrl_chk chk (.*);

// file: rios_plc_model.sv
// Master equipment model that drives the select and strobe pins
`timescale 1ns/1ps
module rios_plc_model
(
  // Clock
  input wire ref_clk,
  // Requests from the bench
  input wire plc_go,
  input wire plc_alarm,
  input wire [4:0] plc_num,
  output wire plc_busy,
  // Remote input pins
  output logic [4:0] robot_select_bits = 5'h00,
  output logic select_output_robot = 1'b0,
  output logic [3:0] alarm_select_bits = 4'h0,
  output logic alarm_clear_request = 1'b0
);
  logic [2:0] step_r = 3'h0;
  logic kind_r = 1'b0;
  assign plc_busy = step_r != 3'h0;
  // Bits settle two edges before the strobe; stale bits are scrambled after
  always @(posedge ref_clk)
  begin
    step_r <= plc_go ? 3'h1 : (plc_busy ? step_r + 3'h1 : 3'h0);
    if (plc_go)
      kind_r <= plc_alarm;
    if (plc_go && plc_alarm)
      alarm_select_bits <= plc_num[3:0];
    if (plc_go && !plc_alarm)
      robot_select_bits <= plc_num;
    if (step_r == 3'h2)
    begin
      alarm_clear_request <= kind_r;
      select_output_robot <= !kind_r;
    end
    if (step_r == 3'h4)
    begin
      alarm_clear_request <= 1'b0;
      select_output_robot <= 1'b0;
    end
    // Released lines must not keep showing the old number
    if (step_r == 3'h6)
    begin
      alarm_select_bits <= ~alarm_select_bits;
      robot_select_bits <= ~robot_select_bits;
    end
  end
endmodule

// file: remote_io_status_control_tb_top.sv
// Self-checking bench for the remote I/O status block
`timescale 1ns/1ps
`include "rios_defs.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module remote_io_status_control_tb_top;
  logic ref_clk = 0, nrst = 0, hsel = 0, hwrite = 0, command_is_high_power = 0;
  logic [31:0] haddr = 0, hwdata = 0, obs, rd, ev, mv, r, e;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic expert_input = 0, forced_low_power_input = 0, reset_input = 0, command_start = 0;
  logic startup_done = 0, task_running = 0, task_paused = 0, error_event = 0;
  logic estop_active = 0, guard_open = 0, critical_error = 0, warning_event = 0;
  logic command_done = 0, plc_go = 0, plc_alarm = 0, f;
  logic [15:0] robot_motor_on = 0, robot_at_home = 0, robot_high_power = 0;
  logic [15:0] robot_uncalibrated = 0, robot_await_recovery = 0, robot_in_recovery = 0;
  logic [4:0] plc_num = 0, n;
  logic [4:0] tab [3] = '{5'h03, 5'h10, 5'h00};
  wire [31:0] hrdata;
  wire [8:0] alarm_clear_pulse;
  wire [4:0] robot_select_bits;
  wire [3:0] alarm_select_bits;
  wire hreadyout, hresp, ready_flag, running_flag, paused_flag, error_flag;
  wire emergency_stop_flag, guard_open_flag, fatal_error_flag, warning_flag;
  wire motors_energized_flag, home_position_flag, high_power_flag, calibration_needed_flag;
  wire recovery_pending_flag, recovery_active_flag, command_busy_flag, command_reject_flag;
  wire stop_all_pulse, stop_ordinary_pulse, temp_stop_level, force_low_power;
  wire high_power_accept, command_accept_pulse, select_output_robot, alarm_clear_request;
  wire plc_busy;
  wire hready = hreadyout;
  int n_errors = 0, num_checks = 0, seed = 90, k;
  logic [31:0] eq [$];
  logic [31:0] mq [$];
  event got;

  always #4 ref_clk = ~ref_clk;
  rios_ctrl dut (.*);
  rios_plc_model plc (.*);

  // Oldest note against each observed result
  always @(got)
  begin
    mv = mq.pop_front();
    ev = eq.pop_front();
    `CHK(obs & mv, ev)
  end

  // ***********************
  // Bus and pin tasks
  // ***********************
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task rdx(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    eq.push_back(x);
    mq.push_back(m);
    bus(0, a, 0);
    obs = rd;
    ->got;
  endtask
  // Action outputs one edge after the input edge
  task snap(input logic [3:0] x, input logic [3:0] m);
    eq.push_back(x);
    mq.push_back(m);
    @(posedge ref_clk);
    #1;
    obs = {stop_all_pulse, temp_stop_level, force_low_power, high_power_accept};
    ->got;
  endtask
  task plcx(input logic a, input logic [4:0] v);
    @(posedge ref_clk);
    plc_go <= 1;
    plc_alarm <= a;
    plc_num <= v;
    @(posedge ref_clk) plc_go <= 0;
    #1;
    wait (!plc_busy);
  endtask
  task stop_test;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Cut a hang short
  initial
  begin
    #100000;
    n_errors++;
    stop_test;
  end

  // Main sequence
  initial
  begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1;
    rdx(`RIOS_OFS_PREF, 0, 32'h3);
    rdx(`RIOS_OFS_ROBOT, 0, 32'h1f);
    rdx(8'h10, 0, 32'hffffffff);
    // Random core state into the status word
    repeat (8)
    begin
      r = $random(seed);
      @(posedge ref_clk);
      {startup_done, task_running, task_paused, estop_active, guard_open, warning_event} <= r[5:0];
      robot_await_recovery <= {15'h0, r[6]};
      robot_in_recovery <= {r[7], 15'h0};
      e = {18'h0, r[7], r[6], 4'h0, r[0], 1'b0, r[1], r[2], 1'b0, r[3], r[4] & ~r[3], r[5] & ~r[4]};
      rdx(`RIOS_OFS_STATUS, e, 32'h30b7);
    end
    // Command, reject while busy, expert fall in between
    @(posedge ref_clk) command_start <= 1;
    @(posedge ref_clk) command_start <= 0;
    @(posedge ref_clk) command_start <= 1;
    @(posedge ref_clk) expert_input <= 1;
    @(posedge ref_clk) expert_input <= 0;
    rdx(`RIOS_OFS_STATUS, 32'hc000, 32'hc000);
    @(posedge ref_clk) command_done <= 1;
    @(posedge ref_clk) command_done <= 0;
    rdx(`RIOS_OFS_STATUS, 32'h8000, 32'hc000);
    // Output robot selection, all robots last
    r = $random(seed);
    @(posedge ref_clk);
    robot_motor_on <= r[15:0];
    robot_at_home <= r[31:16];
    robot_high_power <= r[23:8];
    robot_uncalibrated <= ~r[15:0];
    foreach (tab[i])
    begin
      n = tab[i];
      k = n - 1;
      plcx(0, n);
      if (n == 5'h00)
        e = {|robot_uncalibrated, |robot_high_power, &robot_at_home, |robot_motor_on};
      else
        e = {robot_uncalibrated[k], robot_high_power[k], robot_at_home[k], robot_motor_on[k]};
      rdx(`RIOS_OFS_ROBOT, n, 32'h1f);
      rdx(`RIOS_OFS_STATUS, e << 8, 32'hf00);
    end
    // Every alarm number, then one out of range
    for (int a = 1; a < 11; a++)
    begin
      plcx(1, a);
      rdx(`RIOS_OFS_ALARM, a == 10 ? 32'h0 : 32'h1 << (a - 1), 32'h1ff);
    end
    // Both preference bits against both input edges
    for (int p = 0; p < 4; p++)
    begin
      bus(1, `RIOS_OFS_PREF, p);
      for (int v = 1; v >= 0; v--)
      begin
        f = v[0] ^ p[0];
        @(posedge ref_clk) forced_low_power_input <= v[0];
        snap({!p[1], p[1] & f, p[1] ? f : 1'b1, !f}, 4'hf);
      end
    end
    // High power command: taken out of forcing, refused inside it
    @(posedge ref_clk);
    command_start <= 0;
    command_is_high_power <= 1;
    forced_low_power_input <= 1;
    @(posedge ref_clk) command_start <= 1;
    rdx(`RIOS_OFS_STATUS, 32'h4000, 32'hc000);
    @(posedge ref_clk) command_done <= 1;
    @(posedge ref_clk);
    command_done <= 0;
    command_start <= 0;
    forced_low_power_input <= 0;
    @(posedge ref_clk) command_start <= 1;
    rdx(`RIOS_OFS_STATUS, 32'h8000, 32'hc000);
    // Error cleared by reset input, fatal error kept
    @(posedge ref_clk) error_event <= 1;
    @(posedge ref_clk) error_event <= 0;
    rdx(`RIOS_OFS_STATUS, 32'h8, 32'h8);
    @(posedge ref_clk) critical_error <= 1;
    @(posedge ref_clk) critical_error <= 0;
    @(posedge ref_clk) reset_input <= 1;
    @(posedge ref_clk) reset_input <= 0;
    rdx(`RIOS_OFS_STATUS, 32'h40, 32'h48);
    // Restart mid-run: output robot back to all, fatal error gone
    plcx(0, 5'h07);
    @(posedge ref_clk) nrst <= 0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1;
    rdx(`RIOS_OFS_ROBOT, 0, 32'h1f);
    rdx(`RIOS_OFS_STATUS, 0, 32'h40);
    stop_test;
  end
endmodule
